// file: src/nve_pkg.sv
// Shared constants for the data EEPROM access controller.
package nve_pkg;

    // ------------------------------------------------------------------
    // Storage geometry
    // ------------------------------------------------------------------
    localparam int NVE_AW = 6;                 // Address field width.
    localparam int NVE_DEPTH = 64;             // Bytes of storage.

    // ------------------------------------------------------------------
    // Register placement
    // ------------------------------------------------------------------
    localparam logic [7:0] NVE_CTRL_OFS = 8'h40;    // Control, sector 1.
    localparam logic [7:0] NVE_CTRL_SECT = 8'h01;   // Sector of control.
    localparam logic [7:0] NVE_ADDR_OFS = 8'h1c;    // Address, sector 0.
    localparam logic [7:0] NVE_DATA_OFS = 8'h1d;    // Data, sector 0.
    localparam logic [7:0] NVE_SFR_SECT = 8'h00;    // Sector of addr/data.

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int NVE_RD_BIT = 0;             // Read start.
    localparam int NVE_FETCH_ENABLE_BIT = 1;           // Read enable gate.
    localparam int NVE_WR_BIT = 2;             // Write start.
    localparam int NVE_PROGRAM_ENABLE_BIT = 3;           // Write enable gate.

    // ------------------------------------------------------------------
    // Reset values and timing counts
    // ------------------------------------------------------------------
    localparam logic [7:0] NVE_RST_BYTE = 8'h00;    // Byte registers and cells.
    localparam logic [3:0] NVE_RST_CTRL = 4'h0;     // Control bits.
    localparam logic [3:0] NVE_RD_CYCLES = 4'h2;    // Read length, mclk.
    localparam logic [7:0] NVE_WR_TICKS = 8'h08;    // Write, timer ticks.

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        NVE_IDLE = 2'b00,
        NVE_READ = 2'b01,
        NVE_WRITE = 2'b10
    } nve_state_e;

endpackage

// file: src/nve_mem_if.sv
// Port bundle between the access sequencer and the byte array.
`timescale 1ns/1ps
interface nve_mem_if;
    import nve_pkg::*;
    logic we;                   // One-cycle write strobe.
    logic [NVE_AW-1:0] addr;    // Byte index.
    logic [7:0] wdata;          // Byte to store.
    logic [7:0] rdata;          // Byte at addr.
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface

// file: src/nve_array.sv
// Flip-flop byte array that stands in for the EEPROM cells.
`timescale 1ns/1ps
module nve_array
    import nve_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    nve_mem_if.mem port
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Cells reset to zero only so simulation starts defined; a real part
    // keeps its contents across power cycles.
    logic [7:0] cell_r [NVE_DEPTH];

    // Read path is a plain index; the sequencer samples it.
    assign port.rdata = cell_r[port.addr];

    // Single byte written at the end of a write cycle.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < NVE_DEPTH; i++)
                cell_r[i] <= NVE_RST_BYTE;
        end
        else if (port.we)
        begin
            cell_r[port.addr] <= port.wdata;
        end
    end

endmodule

// file: src/nve_ctrl.sv
// Data EEPROM access controller: registers, sequencer and done flag.
//
// How it works
// - 64 bytes, 6-bit address, high bits read zero.
// - Control sits at 40H of sector 1.
// - Bit 3 gates every write.
// - Bit 1 gates every read.
// - Bit 2 starts write; hardware clears it.
// - Bit 0 starts read; hardware clears it.
// - Write start ignored without prior write enable.
// - Read start ignored without prior read enable.
// - Read byte stays in data register.
// - Write timed by asynchronous timer ticks.
// - All registers reset to zero.
// - Write end sets done flag; request gated by enables.
// - Service clears flag and global enable.
`timescale 1ns/1ps
module nve_ctrl
    import nve_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] ptr_high_byte,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata_r,
    input wire logic sub_clock,
    input wire logic nv_done_irq_en,
    input wire logic global_irq_en,
    input wire logic stack_full,
    input wire logic irq_ack,
    output logic irq_req_r,
    output logic global_irq_clr_r,
    output logic nv_done_flag_r
);

    localparam int RD_LEN = int'(NVE_RD_CYCLES); // Read length for checks.

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    logic [NVE_AW-1:0] nv_address_r;    // Software address.
    logic [7:0] nv_data_r;              // Software data / read result.
    logic [3:0] nv_control_r;           // Enables and start bits.
    nve_state_e state_r;                // Sequencer state.
    nve_state_e state_nxt;              // Next sequencer state.
    logic [NVE_AW-1:0] op_addr_r;       // Address latched at start.
    logic [7:0] op_data_r;              // Data latched at start.
    logic [7:0] cnt_r;                  // Cycle or tick count.
    logic [2:0] sub_sync_r;             // Sub clock synchroniser + edge.
    nve_mem_if mem ();

    wire ctrl_sel = (ptr_high_byte == NVE_CTRL_SECT)
                    && (sfr_addr == NVE_CTRL_OFS);
    wire addr_sel = (ptr_high_byte == NVE_SFR_SECT)
                    && (sfr_addr == NVE_ADDR_OFS);
    wire data_sel = (ptr_high_byte == NVE_SFR_SECT)
                    && (sfr_addr == NVE_DATA_OFS);
    wire ctrl_wr = sfr_wr && ctrl_sel;
    wire idle = (state_r == NVE_IDLE);

    // Start requests use the enable value held before this write, so an
    // enable set in the same write cannot open its own gate.
    wire wr_go = ctrl_wr && idle && sfr_wdata[NVE_WR_BIT]
                 && nv_control_r[NVE_PROGRAM_ENABLE_BIT];
    wire rd_go = ctrl_wr && idle && sfr_wdata[NVE_RD_BIT]
                 && !sfr_wdata[NVE_WR_BIT]
                 && nv_control_r[NVE_FETCH_ENABLE_BIT];

    // Timer tick: rising edge seen after two synchronising stages.
    wire sub_tick = sub_sync_r[1] && !sub_sync_r[2];
    wire rd_end = (state_r == NVE_READ) && (cnt_r == 8'h01);
    wire wr_end = (state_r == NVE_WRITE) && sub_tick
                  && (cnt_r == 8'h01);

    // Read-back mux; unimplemented bits come back as zero.
    wire [7:0] rdata_nxt =
        ctrl_sel ? {4'h0, nv_control_r} :
        addr_sel ? {{(8 - NVE_AW){1'b0}}, nv_address_r} :
        data_sel ? nv_data_r : 8'h00;

    assign mem.addr = op_addr_r;
    assign mem.wdata = op_data_r;
    assign mem.we = wr_end;

    // ------------------------------------------------------------------
    // Byte array
    // ------------------------------------------------------------------
    nve_array u_array
    (
        .mclk(mclk),
        .rst_b(rst_b),
        .port(mem.mem)
    );

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    // A simultaneous read and write request starts only the write.
    always_comb
    begin
        case (state_r)
            NVE_IDLE:
                state_nxt = wr_go ? NVE_WRITE :
                            rd_go ? NVE_READ : NVE_IDLE;
            NVE_READ:
                state_nxt = rd_end ? NVE_IDLE : NVE_READ;
            NVE_WRITE:
                state_nxt = wr_end ? NVE_IDLE : NVE_WRITE;
            default:
                state_nxt = NVE_IDLE;
        endcase
    end

    // Sequencer state register.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            state_r <= NVE_IDLE;
        else
            state_r <= state_nxt;
    end

    // Two stages of synchroniser plus one stage for edge detection.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            sub_sync_r <= 3'h0;
        else
            sub_sync_r <= {sub_sync_r[1:0], sub_clock};
    end

    // ------------------------------------------------------------------
    // Cycle length counter
    // ------------------------------------------------------------------
    // Reads count mclk cycles; writes count timer ticks only.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_r <= NVE_RST_BYTE;
        else if (wr_go)
            cnt_r <= NVE_WR_TICKS;
        else if (rd_go)
            cnt_r <= {4'h0, NVE_RD_CYCLES};
        else if (state_r == NVE_READ || (state_r == NVE_WRITE && sub_tick))
            cnt_r <= cnt_r - 8'h01;
    end

    // Operands frozen at start so later register writes cannot corrupt
    // the cycle in progress.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            op_addr_r <= '0;
            op_data_r <= NVE_RST_BYTE;
        end
        else if (wr_go || rd_go)
        begin
            op_addr_r <= nv_address_r;
            op_data_r <= nv_data_r;
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // Address register: low bits only are stored.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            nv_address_r <= '0;
        else if (sfr_wr && addr_sel)
            nv_address_r <= sfr_wdata[NVE_AW-1:0];
    end

    // Data register: the finished read overrides a same-cycle write.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            nv_data_r <= NVE_RST_BYTE;
        else if (rd_end)
            nv_data_r <= mem.rdata;
        else if (sfr_wr && data_sel)
            nv_data_r <= sfr_wdata;
    end

    // Control register. Enables follow software; start bits are only set
    // through an accepted request and cleared by the cycle's end.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            nv_control_r <= NVE_RST_CTRL;
        else
        begin
            if (ctrl_wr)
            begin
                nv_control_r[NVE_PROGRAM_ENABLE_BIT] <= sfr_wdata[NVE_PROGRAM_ENABLE_BIT];
                nv_control_r[NVE_FETCH_ENABLE_BIT] <= sfr_wdata[NVE_FETCH_ENABLE_BIT];
            end
            if (wr_go)
                nv_control_r[NVE_WR_BIT] <= 1'b1;
            else if (wr_end)
                nv_control_r[NVE_WR_BIT] <= 1'b0;
            if (rd_go)
                nv_control_r[NVE_RD_BIT] <= 1'b1;
            else if (rd_end)
                nv_control_r[NVE_RD_BIT] <= 1'b0;
        end
    end

    // Read data is registered, so it lags the address by one cycle.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            sfr_rdata_r <= NVE_RST_BYTE;
        else
            sfr_rdata_r <= rdata_nxt;
    end

    // ------------------------------------------------------------------
    // Done flag and interrupt request
    // ------------------------------------------------------------------
    // Set wins over the service clear so no completion is lost.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            nv_done_flag_r <= 1'b0;
            irq_req_r <= 1'b0;
            global_irq_clr_r <= 1'b0;
        end
        else
        begin
            if (wr_end)
                nv_done_flag_r <= 1'b1;
            else if (irq_ack)
                nv_done_flag_r <= 1'b0;
            irq_req_r <= nv_done_flag_r && nv_done_irq_en
                         && global_irq_en && !stack_full
                         && !irq_ack;
            global_irq_clr_r <= irq_ack;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence ctl_write_s(int b);
        ctrl_wr && idle && sfr_wdata[b];
    endsequence

    sequence wr_started_s;
        ##1 (state_r == NVE_WRITE) && nv_control_r[NVE_WR_BIT];
    endsequence

    wr_gate_a: assert property (ctl_write_s(NVE_WR_BIT)
        and !nv_control_r[NVE_PROGRAM_ENABLE_BIT] |=> state_r != NVE_WRITE)
        else $error("write started without write enable");
    rd_gate_a: assert property (ctl_write_s(NVE_RD_BIT)
        and !nv_control_r[NVE_FETCH_ENABLE_BIT] |=> state_r != NVE_READ)
        else $error("read started without read enable");
    wr_start_a: assert property (ctl_write_s(NVE_WR_BIT)
        and nv_control_r[NVE_PROGRAM_ENABLE_BIT] |-> wr_started_s)
        else $error("enabled write request did not start");
    rd_len_a: assert property ($rose(state_r == NVE_READ)
        |-> nv_control_r[NVE_RD_BIT] ##RD_LEN !nv_control_r[NVE_RD_BIT])
        else $error("read cycle length wrong");
    wr_end_flag_a: assert property ($fell(nv_control_r[NVE_WR_BIT])
        |-> nv_done_flag_r && $past(sub_tick))
        else $error("write end without flag or tick");
    addr_hi_zero_a: assert property ($past(addr_sel)
        |-> sfr_rdata_r[7:NVE_AW] == 2'b00)
        else $error("unused address bits read nonzero");
    ctrl_place_a: assert property ($past(ctrl_sel)
        |-> sfr_rdata_r == {4'h0, $past(nv_control_r)})
        else $error("control register not readable at its place");
    rd_keep_a: assert property (idle && !(sfr_wr && data_sel)
        |=> $stable(nv_data_r))
        else $error("data register changed with no access");
    op_latch_a: assert property (!idle && !wr_go && !rd_go
        |=> $stable(op_addr_r) && $stable(op_data_r))
        else $error("operands changed during a cycle");
    irq_gate_a: assert property (irq_req_r
        |-> $past(nv_done_flag_r && nv_done_irq_en && global_irq_en))
        else $error("interrupt raised without flag and enables");
endmodule

// file: bench/data_eeprom_access_ctrl_test.sv
// Self-checking testbench for the data EEPROM access controller.
`timescale 1ns/1ps
module data_eeprom_access_ctrl_test;
    import nve_pkg::*;

    // ----------------------------------------------------------------
    // Design ports and bench state
    // ----------------------------------------------------------------
    logic mclk;
    logic rst_b;
    logic [7:0] sfr_addr;
    logic [7:0] ptr_high_byte;
    logic sfr_wr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata_r;
    logic sub_clock;
    logic nv_done_irq_en;
    logic global_irq_en;
    logic stack_full;
    logic irq_ack;
    logic irq_req_r;
    logic global_irq_clr_r;
    logic nv_done_flag_r;
    int num_errors;
    int num_checks;
    int seed;
    logic [7:0] mem [0:63];  // Expected cell contents, all zero at reset.

    nve_ctrl nve_ctrl_inst (
        .mclk(mclk),
        .rst_b(rst_b),
        .sfr_addr(sfr_addr),
        .ptr_high_byte(ptr_high_byte),
        .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata),
        .sfr_rdata_r(sfr_rdata_r),
        .sub_clock(sub_clock),
        .nv_done_irq_en(nv_done_irq_en),
        .global_irq_en(global_irq_en),
        .stack_full(stack_full),
        .irq_ack(irq_ack),
        .irq_req_r(irq_req_r),
        .global_irq_clr_r(global_irq_clr_r),
        .nv_done_flag_r(nv_done_flag_r)
    );

    // The timer clock runs at an odd period so it never locks to mclk.
    always #2.5 mclk = ~mclk;
    always #43 sub_clock = ~sub_clock;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Compares one byte and reports a difference at once.
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Expected read-back of the address register: upper bits are zero.
    function automatic logic [7:0] addr_view(input logic [7:0] wr);
        return {2'b00, wr[5:0]};
    endfunction

    // A request needs both enables and room on the stack.
    function automatic logic irq_expect(input logic gie, input logic lie,
                                        input logic full);
        return gie & lie & ~full;
    endfunction

    // One-cycle write strobe; a free cycle follows so strobes never merge.
    task automatic reg_wr(input logic [7:0] sect, input logic [7:0] ofs,
                          input logic [7:0] val);
        @(negedge mclk);
        ptr_high_byte = sect;
        sfr_addr = ofs;
        sfr_wdata = val;
        sfr_wr = 1'b1;
        @(negedge mclk);
        sfr_wr = 1'b0;
    endtask

    // Read data is registered, so it is taken one cycle after the address.
    task automatic reg_rd(input logic [7:0] sect, input logic [7:0] ofs,
                          output logic [7:0] val);
        @(negedge mclk);
        ptr_high_byte = sect;
        sfr_addr = ofs;
        @(negedge mclk);
        val = sfr_rdata_r;
    endtask

    // Polls a control bit until it clears; a stuck bit ends the run.
    task automatic poll_clear(input int bitpos, output logic [7:0] val);
        int n;
        for (n = 0; n < 400; n++)
        begin
            reg_rd(NVE_CTRL_SECT, NVE_CTRL_OFS, val);
            if (val[bitpos] === 1'b0)
                return;
        end
        check("control poll", {7'h00, val[bitpos]}, 8'h00);
        give_verdict();
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [7:0] v;
        logic [7:0] d;
        logic [5:0] a;
        logic exp_irq;
        mclk = 1'b0;
        sub_clock = 1'b0;
        rst_b = 1'b0;
        sfr_addr = 8'h00;
        ptr_high_byte = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        nv_done_irq_en = 1'b0;
        global_irq_en = 1'b0;
        stack_full = 1'b0;
        irq_ack = 1'b0;
        num_errors = 0;
        num_checks = 0;
        seed = 32'h0ba680a0;
        for (int k = 0; k < 64; k++)
            mem[k] = 8'h00;
        repeat (10) @(negedge mclk);
        rst_b = 1'b1;

        // Every register and the flag start cleared.
        reg_rd(NVE_CTRL_SECT, NVE_CTRL_OFS, v);
        check("control reset", v, 8'h00);
        reg_rd(NVE_SFR_SECT, NVE_ADDR_OFS, v);
        check("address reset", v, 8'h00);
        reg_rd(NVE_SFR_SECT, NVE_DATA_OFS, v);
        check("data reset", v, 8'h00);
        check("flag reset", {7'h00, nv_done_flag_r}, 8'h00);
        $display("test reset done");

        // Address bits above the array width read back as zero.
        reg_wr(NVE_SFR_SECT, NVE_ADDR_OFS, 8'hff);
        reg_rd(NVE_SFR_SECT, NVE_ADDR_OFS, v);
        check("address width", v, addr_view(8'hff));
        // Starts without their enables must leave data and flag alone.
        reg_wr(NVE_SFR_SECT, NVE_DATA_OFS, 8'h5a);
        reg_wr(NVE_CTRL_SECT, NVE_CTRL_OFS, 8'h04);
        reg_rd(NVE_CTRL_SECT, NVE_CTRL_OFS, v);
        check("ungated write", v, 8'h00);
        reg_wr(NVE_CTRL_SECT, NVE_CTRL_OFS, 8'h01);
        reg_rd(NVE_CTRL_SECT, NVE_CTRL_OFS, v);
        check("ungated read", v, 8'h00);
        repeat (200) @(negedge mclk);
        reg_rd(NVE_SFR_SECT, NVE_DATA_OFS, v);
        check("data kept", v, 8'h5a);
        check("no flag", {7'h00, nv_done_flag_r}, 8'h00);
        $display("test gates done");

        // Random write and read-back; first two use the end addresses.
        for (int i = 0; i < 8; i++)
        begin
            a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($random(seed));
            d = 8'($random(seed));
            reg_wr(NVE_SFR_SECT, NVE_ADDR_OFS, {2'b00, a});
            reg_wr(NVE_SFR_SECT, NVE_DATA_OFS, d);
            global_irq_en = 1'b0;
            reg_wr(NVE_CTRL_SECT, NVE_CTRL_OFS, 8'h08);
            reg_wr(NVE_CTRL_SECT, NVE_CTRL_OFS, 8'h0c);
            mem[a] = d;
            // Interrupt gating is drawn at random except on the first pass.
            global_irq_en = (i == 0) ? 1'b1 : 1'($random(seed));
            nv_done_irq_en = (i == 0) ? 1'b1 : 1'($random(seed));
            stack_full = (i == 0) ? 1'b0 : 1'($random(seed));
            exp_irq = irq_expect(global_irq_en, nv_done_irq_en, stack_full);
            // Rewriting address and data mid-cycle must not reach the cell.
            reg_wr(NVE_SFR_SECT, NVE_ADDR_OFS, {2'b00, ~a});
            reg_wr(NVE_SFR_SECT, NVE_DATA_OFS, ~d);
            poll_clear(NVE_WR_BIT, v);
            check("write end control", v, 8'h08);
            check("done flag", {7'h00, nv_done_flag_r}, 8'h01);
            check("irq request", {7'h00, irq_req_r}, {7'h00, exp_irq});
            // Servicing drops flag and request and pulses the enable clear.
            @(negedge mclk);
            irq_ack = 1'b1;
            @(negedge mclk);
            irq_ack = 1'b0;
            check("flag cleared", {7'h00, nv_done_flag_r}, 8'h00);
            check("irq dropped", {7'h00, irq_req_r}, 8'h00);
            check("enable clear", {7'h00, global_irq_clr_r}, 8'h01);
            @(negedge mclk);
            check("clear pulse", {7'h00, global_irq_clr_r}, 8'h00);

            // Address is loaded afresh for every read.
            reg_wr(NVE_SFR_SECT, NVE_ADDR_OFS, {2'b00, a});
            reg_wr(NVE_CTRL_SECT, NVE_CTRL_OFS, 8'h02);
            reg_wr(NVE_CTRL_SECT, NVE_CTRL_OFS, 8'h03);
            poll_clear(NVE_RD_BIT, v);
            check("read end control", v, 8'h02);
            reg_rd(NVE_SFR_SECT, NVE_DATA_OFS, v);
            check("read data", v, mem[a]);
            repeat (20) @(negedge mclk);
            reg_rd(NVE_SFR_SECT, NVE_DATA_OFS, v);
            check("read data held", v, mem[a]);
            $display("test pass %0d at %h done", i, a);
        end
        give_verdict();
    end
endmodule
